// ---- ifb_flag_bank.sv ----
// Notes on behaviour
// R01: Pin level word shows live levels of pins 1-15, only for pins set as inputs.
// R02: Log not-empty word: log 1 bit 0, log 2 bit 1, 1 while holding entries.
// R03: Log full word: log 1 bit 0, log 2 bit 1, 1 while full.
// R04: Log watermark word: log 1 bit 0, log 2 bit 1, 1 once watermark reached.
// R05: Transfer complete reads 1 only when enabled write buffers full, read buffers empty.
// R06: Speaker shutdown raw bit 0 reads 1 after overheat or short shutdown.
// R07: After reset boot-complete mask is 0, every other mask is 1.
// R08: Sticky flags reset to 0, hold, and clear only by writing 1.
// R09: Host port error, clock fail and boot flags set on rising edges.
// R10: Five clock condition flags capture rising edges.
// R11: Accessory detect flags set per detection event; headphone sense on rising edge.
// R12: Clamp and both jack inputs have separate rise and fall flags.
// R13: Three signal-detect flags set on both edges.
// R14: Sixteen processor request flags, request n at bit n-1, rising edge.
// R15: Speaker short flag on both edges, earpiece and headphone shorts rising only.
// R16: Enable-done and disable-done flags set on rising edge of completion.
// R17: Overheat warning and overheat rising; speaker-off flag on both edges.
// R18: Per-pin edge flag, pin n at bit n-1, both edges.
// R19: One mask bit per flag; 1 suppresses its contribution.
// R20: Summary is the OR of all unmasked sticky flags.
// R21: Polarity select 0 gives active high line, 1 active low; resets to 1.
// R22: Every source is synchronised before edge detection, at most one flag set per transition.
// R23: Raw status follows sources continuously; writes to it are ignored.
module ifb_flag_bank
	import ifb_pkg::*;
#(
	parameter int unsigned ADDR_W = 16,
	parameter int unsigned N_DMA  = 8
) (
	// Clock and reset
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_rst_b,
	// Event and level sources
	input  wire ifb_events_type       i_events,
	input  wire logic [N_DMA-1:0]     i_write_transfer_buffers_en,
	input  wire logic [N_DMA-1:0]     i_write_transfer_buffers_filled,
	input  wire logic [N_DMA-1:0]     i_read_transfer_buffers_en,
	input  wire logic [N_DMA-1:0]     i_read_transfer_buffers_emptied,
	input  wire logic [14:0]          i_pin_is_input,
	// Interrupt line
	output logic                      o_irq_line,
	// AXI4-Lite write address
	input  wire logic                 i_s_axi_awvalid,
	output logic                      o_s_axi_awready,
	input  wire logic [ADDR_W-1:0]    i_s_axi_awaddr,
	input  wire logic [2:0]           i_s_axi_awprot,
	// AXI4-Lite write data
	input  wire logic                 i_s_axi_wvalid,
	output logic                      o_s_axi_wready,
	input  wire logic [31:0]          i_s_axi_wdata,
	input  wire logic [3:0]           i_s_axi_wstrb,
	// AXI4-Lite write response
	output logic                      o_s_axi_bvalid,
	input  wire logic                 i_s_axi_bready,
	output logic [1:0]                o_s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                 i_s_axi_arvalid,
	output logic                      o_s_axi_arready,
	input  wire logic [ADDR_W-1:0]    i_s_axi_araddr,
	input  wire logic [2:0]           i_s_axi_arprot,
	// AXI4-Lite read data
	output logic                      o_s_axi_rvalid,
	input  wire logic                 i_s_axi_rready,
	output logic [31:0]               o_s_axi_rdata,
	output logic [1:0]                o_s_axi_rresp
);

	// Elaboration checks
	if (ADDR_W < REG_IDX_W + 2) begin : g_bad_addr
		$error("ADDR_W too narrow for the register map");
	end
	if (N_DMA < 1) begin : g_bad_dma
		$error("N_DMA must be at least one");
	end

	localparam int unsigned SRC_W = $bits(ifb_events_type) + 1;

	// Transfer status folds per-buffer states; disabled buffers do not hold it off
	// R05: transfer complete condition
	wire logic dma_done_raw = (&(~i_write_transfer_buffers_en | i_write_transfer_buffers_filled)) &
	                          (&(~i_read_transfer_buffers_en | i_read_transfer_buffers_emptied));

	wire logic [SRC_W-1:0] src_vec = {i_events, dma_done_raw};

	logic [SRC_W-1:0] sync1_reg;
	logic [SRC_W-1:0] sync2_reg;
	logic [SRC_W-1:0] sync3_reg;
	logic [SRC_W-1:0] level_reg;
	logic [SRC_W-1:0] level_next;
	logic [SRC_W-1:0] rise_vec;
	logic [SRC_W-1:0] fall_vec;

	// Three-stage synchroniser and agreement filter per source bit
	for (genvar b = 0; b < SRC_W; b++) begin : g_sync
		// R22: change counts once stages two and three agree
		assign level_next[b] = (sync2_reg[b] == sync3_reg[b]) ? sync3_reg[b] : level_reg[b];
		assign rise_vec[b]   = level_next[b] & ~level_reg[b];
		assign fall_vec[b]   = ~level_next[b] & level_reg[b];
	end

	// Synchroniser flops; glitches from the combined transfer term are filtered here too
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			level_reg <= '0;
		end else begin
			sync1_reg <= src_vec;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			level_reg <= level_next;
		end
	end

	// Structured views of levels and edges
	ifb_events_type lvl;
	ifb_events_type rs;
	ifb_events_type fl;
	wire logic      dsp_transfer_complete = level_reg[0];
	assign lvl = ifb_events_type'(level_reg[SRC_W-1:1]);
	assign rs  = ifb_events_type'(rise_vec[SRC_W-1:1]);
	assign fl  = ifb_events_type'(fall_vec[SRC_W-1:1]);

	// Per-word set vectors, laid out at the flag positions
	logic [15:0] set_vec [N_FLAG_REGS];
	// R09: system word edges
	assign set_vec[0]  = {3'b000, rs.host_port_error, 2'b00, rs.system_clock_fail, 1'b0,
	                      rs.boot_complete, 7'h00};
	// R10: clock condition edges
	assign set_vec[1]  = {rs.always_on_loop_ref_lost, rs.dsp_clock_short, 1'b0, rs.system_clock_short,
	                      rs.always_on_loop_lock, 2'b00, rs.main_loop_lock, 8'h00};
	// R11: detection events and headphone sense
	assign set_vec[2]  = {6'h00, rs.accessory_detect_two, rs.accessory_detect_one, 7'h00,
	                      rs.headphone_sense};
	// R12: separate fall and rise flags
	assign set_vec[3]  = {10'h000, fl.clamp_active, rs.clamp_active, fl.jack_two, rs.jack_two,
	                      fl.jack_one, rs.jack_one};
	// R13: both edges of the activity detectors
	assign set_vec[4]  = {13'h0000, rs.input_activity | fl.input_activity,
	                      rs.compressor_two_activity | fl.compressor_two_activity,
	                      rs.compressor_one_activity | fl.compressor_one_activity};
	// R14: processor requests, request n at bit n-1
	assign set_vec[5]  = rs.dsp_request;
	// R15: speaker short both edges, others rising only
	assign set_vec[6]  = {9'h000, rs.speaker_short | fl.speaker_short, 2'b00,
	                      rs.earpiece_short, rs.headphone_short};
	// R16: enable and disable sequence completion
	assign set_vec[7]  = {9'h000, rs.speaker_on_done, 4'h0, rs.headphone_on_done};
	assign set_vec[8]  = {9'h000, rs.speaker_off_done, 4'h0, rs.headphone_off_done};
	// R17: thermal rising, shutdown both edges
	assign set_vec[9]  = {13'h0000, rs.speaker_hot_warning, rs.speaker_hot,
	                      rs.speaker_off_state | fl.speaker_off_state};
	// R18: per-pin both edges
	assign set_vec[10] = {1'b0, rs.pin_level | fl.pin_level};

	// Write channel holding registers
	logic              aw_full_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic              w_full_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;

	// Read channel registers
	logic              rvalid_reg;
	logic [31:0]       rdata_reg;
	logic [1:0]        rresp_reg;

	// Handshakes; a new write is not taken while its response is pending
	wire logic aw_take = i_s_axi_awvalid & o_s_axi_awready;
	wire logic w_take  = i_s_axi_wvalid & o_s_axi_wready;
	wire logic ar_take = i_s_axi_arvalid & o_s_axi_arready;
	wire logic do_wr   = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign o_s_axi_awready = ~aw_full_reg & ~bvalid_reg;
	assign o_s_axi_wready  = ~w_full_reg & ~bvalid_reg;
	assign o_s_axi_arready = ~rvalid_reg;

	// Byte lanes of the 16-bit register word
	wire logic [12:0] wr_idx  = aw_addr_reg[REG_IDX_W+1:2];
	wire logic [12:0] rd_idx  = i_s_axi_araddr[REG_IDX_W+1:2];
	wire logic [15:0] wr_bits = w_data_reg[15:0] & {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	wire logic        wr_high_zero = ~|aw_addr_reg[ADDR_W-1:REG_IDX_W+2];
	wire logic        rd_high_zero = ~|i_s_axi_araddr[ADDR_W-1:REG_IDX_W+2];

	// Flag and mask storage
	logic [15:0] flag_reg  [N_FLAG_REGS];
	logic [15:0] flag_next [N_FLAG_REGS];
	logic [15:0] mask_reg  [N_FLAG_REGS];
	logic [15:0] mask_next [N_FLAG_REGS];
	logic [N_FLAG_REGS-1:0] wr_flag_hit;
	logic [N_FLAG_REGS-1:0] wr_mask_hit;
	logic [N_FLAG_REGS-1:0] rd_flag_hit;
	logic [N_FLAG_REGS-1:0] rd_mask_hit;
	logic [N_FLAG_REGS-1:0] word_pending;

	for (genvar k = 0; k < N_FLAG_REGS; k++) begin : g_word
		assign wr_flag_hit[k] = do_wr & wr_high_zero & (wr_idx == FLAG_IDX[k]);
		assign wr_mask_hit[k] = do_wr & wr_high_zero & (wr_idx == FLAG_IDX[k] + MASK_IDX_OFFSET);
		assign rd_flag_hit[k] = rd_high_zero & (rd_idx == FLAG_IDX[k]);
		assign rd_mask_hit[k] = rd_high_zero & (rd_idx == FLAG_IDX[k] + MASK_IDX_OFFSET);
		// R08: write one clears, a same-cycle event wins over the clear
		assign flag_next[k] = ((flag_reg[k] & ~(wr_flag_hit[k] ? wr_bits : 16'h0000)) | set_vec[k]) &
		                      FLAG_IMPL[k];
		// R19: lane-wise mask update, reserved bits stay zero
		assign mask_next[k] = wr_mask_hit[k] ?
		                      (((mask_reg[k] & ~{{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}}) | wr_bits) &
		                       FLAG_IMPL[k]) : mask_reg[k];
		// R20: unmasked pending per word
		assign word_pending[k] = |(flag_reg[k] & ~mask_reg[k]);

		// Flag and mask flops per word
		always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
			if (!i_rst_b) begin
				flag_reg[k] <= FLAG_RESET;
				// R07: boot complete unmasked, others masked
				mask_reg[k] <= MASK_RESET[k];
			end else begin
				flag_reg[k] <= flag_next[k];
				mask_reg[k] <= mask_next[k];
			end
		end
	end

	// Line control: polarity select
	logic        pol_reg;
	logic        summary_reg;
	logic        line_reg;
	wire logic   wr_ctrl_hit = do_wr & wr_high_zero & (wr_idx == IDX_LINE_CTRL);
	wire logic   pol_next    = (wr_ctrl_hit & w_strb_reg[1]) ? w_data_reg[POL_BIT] : pol_reg;
	// R20: OR of every unmasked flag
	wire logic   summary_next = |word_pending;
	// R21: polarity 1 drives the line active low
	wire logic   line_next    = pol_reg ? ~summary_reg : summary_reg;
	assign o_irq_line = line_reg;

	// Summary and line are registered so the pin never glitches
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pol_reg     <= POL_RESET;
			summary_reg <= 1'b0;
			line_reg    <= POL_RESET;
		end else begin
			pol_reg     <= pol_next;
			summary_reg <= summary_next;
			line_reg    <= line_next;
		end
	end

	// Raw status words, live from the filtered levels
	// R01: pin levels masked by input configuration
	wire logic [15:0] raw_pin   = {1'b0, lvl.pin_level & i_pin_is_input};
	// R02: log not-empty
	wire logic [15:0] raw_nemp  = {14'h0000, lvl.log_has_entries};
	// R03: log full
	wire logic [15:0] raw_full  = {14'h0000, lvl.log_at_capacity};
	// R04: log watermark
	wire logic [15:0] raw_wmark = {14'h0000, lvl.log_level_reached};
	// R05: transfer complete bit
	wire logic [15:0] raw_xfer  = {15'h0000, dsp_transfer_complete};
	wire logic [15:0] raw_act   = {15'h0000, lvl.dsp_running};
	// R06: speaker shutdown state at bit 0
	wire logic [15:0] raw_spk   = {13'h0000, lvl.speaker_hot_warning, lvl.speaker_hot,
	                               lvl.speaker_off_state};
	wire logic [15:0] ctrl_word = {5'h00, pol_reg, 10'h000};
	wire logic [15:0] sum_word  = {14'h0000, summary_reg, 1'b0};

	// Fixed word decode; raw and summary words are read only
	wire logic rd_raw_pin   = rd_high_zero & (rd_idx == IDX_PIN_LEVEL);
	wire logic rd_raw_nemp  = rd_high_zero & (rd_idx == IDX_LOG_NONEMPTY);
	wire logic rd_raw_full  = rd_high_zero & (rd_idx == IDX_LOG_FULL);
	wire logic rd_raw_wmark = rd_high_zero & (rd_idx == IDX_LOG_WMARK);
	wire logic rd_raw_xfer  = rd_high_zero & (rd_idx == IDX_DSP_XFER);
	wire logic rd_raw_act   = rd_high_zero & (rd_idx == IDX_DSP_ACT);
	wire logic rd_raw_spk   = rd_high_zero & (rd_idx == IDX_SPK_RAW);
	wire logic rd_ctrl      = rd_high_zero & (rd_idx == IDX_LINE_CTRL);
	wire logic rd_sum       = rd_high_zero & (rd_idx == IDX_SUMMARY);
	wire logic rd_fixed_hit = rd_raw_pin | rd_raw_nemp | rd_raw_full | rd_raw_wmark |
	                          rd_raw_xfer | rd_raw_act | rd_raw_spk | rd_ctrl | rd_sum;

	// R23: writes to raw and summary words are accepted without effect
	wire logic wr_ro_hit = wr_high_zero & ((wr_idx == IDX_PIN_LEVEL) | (wr_idx == IDX_LOG_NONEMPTY) |
	                       (wr_idx == IDX_LOG_FULL) | (wr_idx == IDX_LOG_WMARK) |
	                       (wr_idx == IDX_DSP_XFER) | (wr_idx == IDX_DSP_ACT) |
	                       (wr_idx == IDX_SPK_RAW) | (wr_idx == IDX_SUMMARY));
	wire logic wr_mapped = (|wr_flag_hit) | (|wr_mask_hit) | wr_ctrl_hit | (do_wr & wr_ro_hit);

	// Read word selection by one-hot OR
	logic [15:0] rd_word;
	always_comb begin
		rd_word = ({16{rd_raw_pin}} & raw_pin) | ({16{rd_raw_nemp}} & raw_nemp) |
		          ({16{rd_raw_full}} & raw_full) | ({16{rd_raw_wmark}} & raw_wmark) |
		          ({16{rd_raw_xfer}} & raw_xfer) | ({16{rd_raw_act}} & raw_act) |
		          ({16{rd_raw_spk}} & raw_spk) | ({16{rd_ctrl}} & ctrl_word) |
		          ({16{rd_sum}} & sum_word);
		for (int j = 0; j < N_FLAG_REGS; j++) begin
			rd_word = rd_word | ({16{rd_flag_hit[j]}} & flag_reg[j]) |
			          ({16{rd_mask_hit[j]}} & mask_reg[j]);
		end
	end
	wire logic rd_mapped = rd_fixed_hit | (|rd_flag_hit) | (|rd_mask_hit);

	// Write address and data are captured independently, in either order
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= '0;
		end else if (aw_take) begin
			aw_full_reg <= 1'b1;
			aw_addr_reg <= i_s_axi_awaddr;
		end else if (do_wr) begin
			aw_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			w_full_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (w_take) begin
			w_full_reg <= 1'b1;
			w_data_reg <= i_s_axi_wdata;
			w_strb_reg <= i_s_axi_wstrb;
		end else if (do_wr) begin
			w_full_reg <= 1'b0;
		end
	end

	// Write response; an unmapped address answers with a slave error
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (i_s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= RESP_OKAY;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= {16'h0000, rd_word};
			rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (i_s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign o_s_axi_bvalid = bvalid_reg;
	assign o_s_axi_bresp  = bresp_reg;
	assign o_s_axi_rvalid = rvalid_reg;
	assign o_s_axi_rdata  = rdata_reg;
	assign o_s_axi_rresp  = rresp_reg;

endmodule

// ---- ifb_flag_bank_bench.sv ----
module ifb_flag_bank_bench
	import ifb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// Design connections
	logic           i_sys_clk = 1'b0;
	logic           i_rst_b = 1'b0;
	ifb_events_type i_events;
	logic [7:0]     i_write_transfer_buffers_en;
	logic [7:0]     i_write_transfer_buffers_filled;
	logic [7:0]     i_read_transfer_buffers_en;
	logic [7:0]     i_read_transfer_buffers_emptied;
	logic [14:0]    i_pin_is_input;
	logic           o_irq_line;
	logic           i_s_axi_awvalid;
	logic           o_s_axi_awready;
	logic [15:0]    i_s_axi_awaddr;
	logic           i_s_axi_wvalid;
	logic           o_s_axi_wready;
	logic [31:0]    i_s_axi_wdata;
	logic           o_s_axi_bvalid;
	logic [1:0]     o_s_axi_bresp;
	logic           i_s_axi_arvalid;
	logic           o_s_axi_arready;
	logic [15:0]    i_s_axi_araddr;
	logic           o_s_axi_rvalid;
	logic [31:0]    o_s_axi_rdata;
	logic [1:0]     o_s_axi_rresp;
	int             miscompares = 0;
	int             tests_run = 0;

	// Flags after all sources rise, then fall
	localparam logic [15:0] EXP_RISE [11] = '{16'h1280, 16'hd900, 16'h0301, 16'h0015, 16'h0007, 16'hffff,
		16'h004f, 16'h0043, 16'h0043, 16'h0007, 16'h7fff};
	localparam logic [15:0] EXP_FALL [11] = '{16'h0000, 16'h0000, 16'h0000, 16'h002a, 16'h0007, 16'h0000,
		16'h0040, 16'h0000, 16'h0000, 16'h0001, 16'h7fff};

	// 25 MHz clock
	always #20 i_sys_clk = ~i_sys_clk;

	// Responses always accepted
	ifb_flag_bank ifb_flag_bank_i (.i_s_axi_awprot(3'h0), .i_s_axi_wstrb(4'hf), .i_s_axi_bready(1'b1),
		.i_s_axi_arprot(3'h0), .i_s_axi_rready(1'b1), .*);
	ifb_host ifb_host_i (.i_clk(i_sys_clk), .o_awvalid(i_s_axi_awvalid), .o_awaddr(i_s_axi_awaddr),
		.o_wvalid(i_s_axi_wvalid), .o_wdata(i_s_axi_wdata), .i_awready(o_s_axi_awready),
		.i_wready(o_s_axi_wready), .i_bvalid(o_s_axi_bvalid), .i_bresp(o_s_axi_bresp),
		.o_arvalid(i_s_axi_arvalid), .o_araddr(i_s_axi_araddr), .i_arready(o_s_axi_arready),
		.i_rvalid(o_s_axi_rvalid), .i_rdata(o_s_axi_rdata), .i_rresp(o_s_axi_rresp));

	// Shared helpers
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [12:0] x, input logic [15:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		ifb_host_i.rd({1'b0, x, 2'b00}, d, r);
		chk({r, d}, {RESP_OKAY, 16'h0000, e});
	endtask
	task automatic wrc(input logic [12:0] x, input logic [15:0] d);
		logic [1:0] r;
		ifb_host_i.wr({1'b0, x, 2'b00}, d, r);
		chk(r, RESP_OKAY);
	endtask
	// Beyond sync and line latency
	task automatic settle;
		repeat (8) @(posedge i_sys_clk);
	endtask
	task automatic stop_test;
		if (miscompares == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Reset values
	task automatic t_reset;
		chk(o_irq_line, 1'b1);
		for (int i = 0; i < N_FLAG_REGS; i++) begin
			rdc(FLAG_IDX[i], 16'h0000);
			rdc(FLAG_IDX[i] + MASK_IDX_OFFSET, FLAG_IMPL[i] & ((i == 0) ? 16'hff7f : 16'hffff));
		end
		rdc(IDX_LINE_CTRL, 16'h0400);
	endtask

	// All sources move at once
	task automatic t_edges(input logic fall);
		i_events <= fall ? '0 : '1;
		settle;
		for (int i = 0; i < N_FLAG_REGS; i++) begin
			rdc(FLAG_IDX[i], fall ? EXP_FALL[i] : EXP_RISE[i]);
		end
		chk(o_irq_line, fall);
	endtask

	// Write zero keeps, write one clears
	task automatic t_clear;
		wrc(FLAG_IDX[5], 16'h0000);
		rdc(FLAG_IDX[5], 16'hffff);
		for (int i = 0; i < N_FLAG_REGS; i++) begin
			wrc(FLAG_IDX[i], 16'hffff);
		end
		settle;
		chk(o_irq_line, 1'b1);
	endtask

	// Live levels while all sources are high
	task automatic t_raw;
		rdc(IDX_PIN_LEVEL, 16'h5555);
		rdc(IDX_LOG_NONEMPTY, 16'h0003);
		rdc(IDX_LOG_FULL, 16'h0003);
		rdc(IDX_LOG_WMARK, 16'h0003);
		rdc(IDX_SPK_RAW, 16'h0007);
		rdc(IDX_DSP_ACT, 16'h0001);
		wrc(IDX_PIN_LEVEL, 16'h0000);
		rdc(IDX_PIN_LEVEL, 16'h5555);
		i_write_transfer_buffers_en <= 8'h03;
		i_write_transfer_buffers_filled <= 8'h01;
		i_read_transfer_buffers_en <= 8'h04;
		settle;
		rdc(IDX_DSP_XFER, 16'h0000);
		i_write_transfer_buffers_filled <= 8'h83;
		i_read_transfer_buffers_emptied <= 8'h04;
		settle;
		rdc(IDX_DSP_XFER, 16'h0001);
	endtask

	// Masks, summary, polarity, unmapped
	task automatic t_mask;
		logic [31:0] d;
		logic [1:0]  r;
		rdc(IDX_SUMMARY, 16'h0000);
		wrc(FLAG_IDX[10] + MASK_IDX_OFFSET, 16'h7ffe);
		settle;
		rdc(IDX_SUMMARY, 16'h0002);
		chk(o_irq_line, 1'b0);
		wrc(IDX_LINE_CTRL, 16'h0000);
		settle;
		chk(o_irq_line, 1'b1);
		wrc(FLAG_IDX[10], 16'h0001);
		settle;
		rdc(IDX_SUMMARY, 16'h0000);
		chk(o_irq_line, 1'b0);
		ifb_host_i.rd(16'h8000, d, r);
		chk({r, d}, {RESP_SLVERR, 32'h0});
		ifb_host_i.wr(16'h8000, 16'hffff, r);
		chk(r, RESP_SLVERR);
	endtask

	// Main sequence
	initial begin
		i_events = '0;
		i_write_transfer_buffers_en = 8'h00;
		i_write_transfer_buffers_filled = 8'h00;
		i_read_transfer_buffers_en = 8'h00;
		i_read_transfer_buffers_emptied = 8'h00;
		i_pin_is_input = 15'h5555;
		repeat (3) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		@(posedge i_sys_clk);
		t_reset;
		t_edges(1'b0);
		t_raw;
		t_clear;
		t_edges(1'b1);
		t_mask;
		stop_test;
	end

	// Watchdog, about 10000 cycles
	initial begin
		#400000;
		miscompares++;
		stop_test;
	end
endmodule

// ---- ifb_flag_bank_monitor.sv ----
module ifb_flag_bank_monitor
	import ifb_pkg::*;
#(
	parameter int unsigned ADDR_W = 16
) (
	// Clock, reset and line
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst_b,
	input  wire logic              o_irq_line,
	// Write side
	input  wire logic              i_s_axi_awvalid,
	input  wire logic              o_s_axi_awready,
	input  wire logic              i_s_axi_wvalid,
	input  wire logic              o_s_axi_wready,
	input  wire logic              o_s_axi_bvalid,
	input  wire logic              i_s_axi_bready,
	// Read side
	input  wire logic              i_s_axi_arvalid,
	input  wire logic              o_s_axi_arready,
	input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
	input  wire logic              o_s_axi_rvalid,
	input  wire logic              i_s_axi_rready,
	input  wire logic [31:0]       o_s_axi_rdata,
	input  wire logic [1:0]        o_s_axi_rresp
);
	// One clock domain
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_b);

	// Handshake steps
	sequence s_ar_taken;
		i_s_axi_arvalid && o_s_axi_arready;
	endsequence
	sequence s_w_taken;
		i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
	endsequence

	// Bus timing and refusals
	property p_read_answer;
		s_ar_taken |=> o_s_axi_rvalid;
	endproperty
	property p_read_once;
		o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid;
	endproperty
	property p_ar_blocked;
		o_s_axi_rvalid |-> !o_s_axi_arready;
	endproperty
	property p_write_answer;
		s_w_taken |-> ##[1:2] o_s_axi_bvalid;
	endproperty
	property p_write_once;
		o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid;
	endproperty
	property p_w_blocked;
		o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready;
	endproperty
	// Bits above 14 are unmapped
	property p_unmapped_read;
		s_ar_taken ##0 i_s_axi_araddr[ADDR_W-1] |=> o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == 32'h0;
	endproperty
	property p_upper_zero;
		o_s_axi_rvalid |-> o_s_axi_rdata[31:16] == 16'h0000;
	endproperty
	// Line idle just after reset
	property p_line_idle;
		$rose(i_rst_b) |-> o_irq_line [*3];
	endproperty

	a_read_answer: assert property (p_read_answer) else $error("read answer late");
	a_read_once: assert property (p_read_once) else $error("read answer repeated");
	a_ar_blocked: assert property (p_ar_blocked) else $error("read taken while busy");
	a_write_answer: assert property (p_write_answer) else $error("write answer late");
	a_write_once: assert property (p_write_once) else $error("write answer repeated");
	a_w_blocked: assert property (p_w_blocked) else $error("write taken while busy");
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read answered");
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
	a_line_idle: assert property (p_line_idle) else $error("line active after reset");
endmodule

bind ifb_flag_bank ifb_flag_bank_monitor #(.ADDR_W(ADDR_W)) ifb_flag_bank_monitor_i (.*);

// ---- ifb_host.sv ----
module ifb_host (
	// Clock
	input  wire logic        i_clk,
	// Write request and answer
	output logic             o_awvalid,
	output logic [15:0]      o_awaddr,
	output logic             o_wvalid,
	output logic [31:0]      o_wdata,
	input  wire logic        i_awready,
	input  wire logic        i_wready,
	input  wire logic        i_bvalid,
	input  wire logic [1:0]  i_bresp,
	// Read request and answer
	output logic             o_arvalid,
	output logic [15:0]      o_araddr,
	input  wire logic        i_arready,
	input  wire logic        i_rvalid,
	input  wire logic [31:0] i_rdata,
	input  wire logic [1:0]  i_rresp
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus at time zero
	initial begin
		o_awvalid = 1'b0;
		o_awaddr = 16'h0000;
		o_wvalid = 1'b0;
		o_wdata = 32'h0;
		o_arvalid = 1'b0;
		o_araddr = 16'h0000;
	end

	task automatic wr(input logic [15:0] a, input logic [15:0] d, output logic [1:0] r);
		logic pa;
		logic pw;
		pa = 1'b1;
		pw = 1'b1;
		o_awaddr <= a;
		o_awvalid <= 1'b1;
		o_wdata <= {16'h0000, d};
		o_wvalid <= 1'b1;
		while (pa || pw) begin
			@(posedge i_clk);
			if (pa && i_awready) begin
				pa = 1'b0;
				o_awvalid <= 1'b0;
			end
			if (pw && i_wready) begin
				pw = 1'b0;
				o_wvalid <= 1'b0;
			end
		end
		do @(posedge i_clk); while (!i_bvalid);
		r = i_bresp;
	endtask

	// One read
	task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		o_araddr <= a;
		o_arvalid <= 1'b1;
		do @(posedge i_clk); while (!i_arready);
		o_arvalid <= 1'b0;
		do @(posedge i_clk); while (!i_rvalid);
		d = i_rdata;
		r = i_rresp;
	endtask
endmodule

// ---- ifb_pkg.sv ----
package ifb_pkg;

	// Register index width; byte address is four times the index
	localparam int unsigned REG_IDX_W = 13;
	localparam int unsigned REG_W     = 16;

	// Raw status of the first bank, read only
	localparam logic [12:0] IDX_SPK_RAW      = 13'h188e;
	localparam logic [12:0] IDX_PIN_LEVEL    = 13'h1890;
	localparam logic [12:0] IDX_LOG_NONEMPTY = 13'h1895;
	localparam logic [12:0] IDX_LOG_FULL     = 13'h1896;
	localparam logic [12:0] IDX_LOG_WMARK    = 13'h1897;
	localparam logic [12:0] IDX_DSP_XFER     = 13'h1898;
	localparam logic [12:0] IDX_DSP_ACT      = 13'h189d;

	// Sticky flag words of the second bank and their masks
	localparam int unsigned N_FLAG_REGS     = 11;
	localparam logic [12:0] MASK_IDX_OFFSET = 13'h0040;
	localparam logic [12:0] FLAG_IDX [N_FLAG_REGS] = '{
		13'h1900, 13'h1901, 13'h1905, 13'h1906, 13'h1908, 13'h190a,
		13'h190b, 13'h190c, 13'h190d, 13'h190e, 13'h1910};
	// Implemented bits per flag word; all others read zero
	localparam logic [15:0] FLAG_IMPL [N_FLAG_REGS] = '{
		16'h1280, 16'hd900, 16'h0301, 16'h003f, 16'h0007, 16'hffff,
		16'h004f, 16'h0043, 16'h0043, 16'h0007, 16'h7fff};
	// Masks come up set, except boot complete in the system word
	localparam logic [15:0] MASK_RESET [N_FLAG_REGS] = '{
		16'h1200, 16'hd900, 16'h0301, 16'h003f, 16'h0007, 16'hffff,
		16'h004f, 16'h0043, 16'h0043, 16'h0007, 16'h7fff};
	localparam logic [15:0] FLAG_RESET = 16'h0000;

	// Line control and summary
	localparam logic [12:0] IDX_LINE_CTRL = 13'h1a80;
	localparam logic [12:0] IDX_SUMMARY   = 13'h1aa0;
	localparam int unsigned POL_BIT       = 10;
	localparam int unsigned SUMMARY_BIT   = 1;
	localparam logic        POL_RESET     = 1'b1;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Event and level sources from the surrounding units
	typedef struct packed {
		logic        host_port_error;
		logic        system_clock_fail;
		logic        boot_complete;
		logic        always_on_loop_ref_lost;
		logic        dsp_clock_short;
		logic        system_clock_short;
		logic        always_on_loop_lock;
		logic        main_loop_lock;
		logic        accessory_detect_two;
		logic        accessory_detect_one;
		logic        headphone_sense;
		logic        clamp_active;
		logic        jack_two;
		logic        jack_one;
		logic        input_activity;
		logic        compressor_two_activity;
		logic        compressor_one_activity;
		logic [15:0] dsp_request;
		logic        speaker_short;
		logic [1:0]  earpiece_short;
		logic [1:0]  headphone_short;
		logic        speaker_on_done;
		logic [1:0]  headphone_on_done;
		logic        speaker_off_done;
		logic [1:0]  headphone_off_done;
		logic        speaker_hot_warning;
		logic        speaker_hot;
		logic        speaker_off_state;
		logic [14:0] pin_level;
		logic [1:0]  log_has_entries;
		logic [1:0]  log_at_capacity;
		logic [1:0]  log_level_reached;
		logic        dsp_running;
	} ifb_events_type;

endpackage
